/* rtl/isf_pkg.sv */
// constants and types shared by the i2c status flag block
package isf_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register word addresses on the plain register port
	localparam logic [3:0] ADDR_STATUS_ONE = 4'h0;
	localparam logic [3:0] ADDR_STATUS_TWO = 4'h1;
	localparam logic [3:0] ADDR_CTRL = 4'h2;
	localparam logic [3:0] ADDR_BYTE_BUF = 4'h3;

	// control register fields
	localparam int CTRL_W = 4;
	localparam int CTRL_UNIT_ON = 0;
	localparam int CTRL_IRQ_EN = 1;
	localparam int CTRL_GC_EN = 2;
	localparam int CTRL_ACK = 3;
	localparam int CTRL_START = 4;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// status_one fields
	localparam int S1_START_GEN = 0;
	localparam int S1_MS = 1;
	localparam int S1_BYTE_DONE = 3;

	// status_two fields
	localparam int S2_GEN_CALL = 0;
	localparam int S2_BUS_ERR = 1;
	localparam int S2_ARB_LOST = 2;
	localparam int S2_STOP_SEEN = 3;
	localparam int S2_NO_REPLY = 4;
	localparam logic [7:0] STATUS_TWO_RST = 8'h00;

	// bit slot counter: 0 after an ack slot, 8 marks the ack slot itself
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] SLOT_LAST_DATA = 4'h7;
	localparam logic [3:0] SLOT_ACK = 4'h8;
	localparam logic [3:0] SLOT_FRAME_EDGE = 4'h1;

	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [2:0] SYNC_RST = 3'h7;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACTIVE
	} isf_bus_t;

endpackage

/* rtl/isf_pin_sync.sv */
// three-stage synchroniser with edge pulses for one bus pin
`timescale 1ns/1ps
module isf_pin_sync (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	logic [2:0] sync_ff;
	logic [2:0] nxt_sync_ff;
	logic level_ff;
	logic nxt_level_ff;
	logic rise_ff;
	logic nxt_rise_ff;
	logic fall_ff;
	logic nxt_fall_ff;

	// a change counts only once stages two and three agree
	always_comb begin
		nxt_sync_ff = {sync_ff[1:0], pin_i};
		nxt_level_ff = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
		nxt_rise_ff = nxt_level_ff & ~level_ff;
		nxt_fall_ff = ~nxt_level_ff & level_ff;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_ff <= isf_pkg::SYNC_RST;
			level_ff <= isf_pkg::PIN_IDLE;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_sync_ff;
			level_ff <= nxt_level_ff;
			rise_ff <= nxt_rise_ff;
			fall_ff <= nxt_fall_ff;
		end
	end

	assign level_o = level_ff;
	assign rise_o = rise_ff;
	assign fall_o = fall_ff;

endmodule

/* rtl/isf_core.sv */
// status flag logic of a multimaster i2c interface with its register port
// Overview of operation
// - master_slave_flag sets when software requests a transfer, reads 1 as master.
// - master_slave_flag clears on a bus stop or on lost arbitration.
// - turning unit_on off clears every flag here, master_slave_flag too.
// - start_generated_flag sets once our start is on the bus; interrupt if enabled.
// - start_generated_flag clears after a status_one read then byte_buffer write, or when unit_on is off.
// - status_two bits 7 to 5 always read zero.
// - no_reply_flag sets when the ack slot passes unacknowledged; interrupt if enabled.
// - reading status_two clears no_reply, stop, arbitration and bus error flags.
// - no_reply_flag never holds the clock line low.
// - slave with acks on sets stop_detected_flag on stop after ack; no stretch.
// - arbitration_lost_flag sets when another master wins; interrupt, no stretch.
// - an arbitration loss drops the unit back to slave operation.
// - no arbitration is performed during the acknowledge bit.
// - bus_error_flag sets on a misplaced start or stop; interrupt, no stretch.
// - slave sets general_call_flag on general call address while enabled.
// - general_call_flag clears on stop; reading status_two leaves it.
// - clock line is held low while byte_done_flag is set and unit_on is on.
`timescale 1ns/1ps
module isf_core (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	input wire logic byte_done_i,
	input wire logic tx_active_i,
	input wire logic tx_bit_i,
	output logic irq_o
);

	logic [3:0] ctrl_ff;
	logic [3:0] nxt_ctrl_ff;
	logic ms_ff;
	logic nxt_ms_ff;
	logic start_gen_ff;
	logic nxt_start_gen_ff;
	logic start_arm_ff;
	logic nxt_start_arm_ff;
	logic no_reply_ff;
	logic nxt_no_reply_ff;
	logic stop_seen_ff;
	logic nxt_stop_seen_ff;
	logic arb_lost_ff;
	logic nxt_arb_lost_ff;
	logic bus_err_ff;
	logic nxt_bus_err_ff;
	logic gen_call_ff;
	logic nxt_gen_call_ff;
	isf_pkg::isf_bus_t bus_ff;
	isf_pkg::isf_bus_t nxt_bus_ff;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift_ff;
	logic first_ff;
	logic nxt_first_ff;
	logic ack_ff;
	logic nxt_ack_ff;
	logic hold_ff;
	logic nxt_hold_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata_ff;

	logic scl_lvl;
	logic scl_rise;
	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;
	logic unit_on;
	logic wr_ctrl;
	logic wr_buf;
	logic rd_one;
	logic rd_two;
	logic begin_wr;
	logic start_det;
	logic stop_det;
	logic busy;
	logic ack_slot;
	logic start_gen_set;
	logic no_reply_set;
	logic stop_seen_set;
	logic arb_lost_set;
	logic bus_err_set;
	logic gen_call_set;

	function automatic logic acc_hit(input logic [3:0] addr, input logic [3:0] reg_a,
			input logic strobe);
		acc_hit = strobe && (addr == reg_a);
	endfunction

	isf_pin_sync u_scl_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(scl_i),
		.level_o(scl_lvl),
		.rise_o(scl_rise),
		.fall_o()
	);

	isf_pin_sync u_sda_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(sda_i),
		.level_o(sda_lvl),
		.rise_o(sda_rise),
		.fall_o(sda_fall)
	);

	assign unit_on = ctrl_ff[isf_pkg::CTRL_UNIT_ON];
	assign wr_ctrl = acc_hit(reg_addr_i, isf_pkg::ADDR_CTRL, reg_wr_i);
	assign wr_buf = acc_hit(reg_addr_i, isf_pkg::ADDR_BYTE_BUF, reg_wr_i);
	assign rd_one = acc_hit(reg_addr_i, isf_pkg::ADDR_STATUS_ONE, reg_rd_i);
	assign rd_two = acc_hit(reg_addr_i, isf_pkg::ADDR_STATUS_TWO, reg_rd_i);
	assign begin_wr = wr_ctrl && unit_on && reg_wdata_i[isf_pkg::CTRL_START]
		&& reg_wdata_i[isf_pkg::CTRL_UNIT_ON];

	// bus conditions seen on the synchronised pins
	assign start_det = sda_fall && scl_lvl;
	assign stop_det = sda_rise && scl_lvl;
	assign busy = (bus_ff == isf_pkg::BUS_ACTIVE);
	assign ack_slot = scl_rise && busy && (cnt_ff == isf_pkg::SLOT_ACK);

	// flag set events
	assign start_gen_set = start_det && ms_ff;
	assign no_reply_set = ack_slot && sda_lvl && tx_active_i;
	assign stop_seen_set = stop_det && !ms_ff && ctrl_ff[isf_pkg::CTRL_ACK] && ack_ff;
	assign arb_lost_set = scl_rise && busy && ms_ff && tx_active_i && tx_bit_i && !sda_lvl
		&& (cnt_ff != isf_pkg::SLOT_ACK);
	assign bus_err_set = (start_det || stop_det) && busy
		&& (cnt_ff > isf_pkg::SLOT_FRAME_EDGE);
	assign gen_call_set = scl_rise && busy && first_ff && !ms_ff
		&& ctrl_ff[isf_pkg::CTRL_GC_EN]
		&& (cnt_ff == isf_pkg::SLOT_LAST_DATA)
		&& ({shift_ff[6:0], sda_lvl} == isf_pkg::GEN_CALL_ADDR);

	// bus tracking runs whether or not the unit is on
	always_comb begin
		nxt_bus_ff = bus_ff;
		nxt_cnt_ff = cnt_ff;
		nxt_shift_ff = shift_ff;
		nxt_first_ff = first_ff;
		nxt_ack_ff = ack_ff;
		if (scl_rise) begin
			nxt_shift_ff = {shift_ff[6:0], sda_lvl};
		end
		if (start_det) begin
			nxt_bus_ff = isf_pkg::BUS_ACTIVE;
			nxt_cnt_ff = isf_pkg::CNT_RST;
			nxt_first_ff = 1'b1;
			nxt_ack_ff = 1'b0;
		end else if (stop_det) begin
			nxt_bus_ff = isf_pkg::BUS_IDLE;
			nxt_cnt_ff = isf_pkg::CNT_RST;
			nxt_first_ff = 1'b0;
		end else if (scl_rise && busy) begin
			if (cnt_ff == isf_pkg::SLOT_ACK) begin
				nxt_cnt_ff = isf_pkg::CNT_RST;
				nxt_first_ff = 1'b0;
				nxt_ack_ff = ~sda_lvl;
			end else begin
				nxt_cnt_ff = cnt_ff + 4'h1;
			end
		end
	end

	// flags: a set in the same cycle as its clear wins, except against unit_on off, which clears them all
	always_comb begin
		nxt_ctrl_ff = wr_ctrl ? reg_wdata_i[3:0] : ctrl_ff;
		nxt_ms_ff = (ms_ff && !(stop_det || arb_lost_set)) || begin_wr;
		nxt_start_gen_ff = (start_gen_ff && !(wr_buf && start_arm_ff)) || start_gen_set;
		nxt_start_arm_ff = start_arm_ff;
		if (rd_one && start_gen_ff) begin
			nxt_start_arm_ff = 1'b1;
		end else if (wr_buf || !start_gen_ff) begin
			nxt_start_arm_ff = 1'b0;
		end
		nxt_no_reply_ff = (no_reply_ff && !rd_two) || no_reply_set;
		nxt_stop_seen_ff = (stop_seen_ff && !rd_two) || stop_seen_set;
		nxt_arb_lost_ff = (arb_lost_ff && !rd_two) || arb_lost_set;
		nxt_bus_err_ff = (bus_err_ff && !rd_two) || bus_err_set;
		nxt_gen_call_ff = (gen_call_ff && !stop_det) || gen_call_set;
		if (!unit_on) begin
			nxt_ms_ff = 1'b0;
			nxt_start_gen_ff = 1'b0;
			nxt_start_arm_ff = 1'b0;
			nxt_no_reply_ff = 1'b0;
			nxt_stop_seen_ff = 1'b0;
			nxt_arb_lost_ff = 1'b0;
			nxt_bus_err_ff = 1'b0;
			nxt_gen_call_ff = 1'b0;
		end
		// only byte_done and the start flag stretch the clock
		nxt_hold_ff = unit_on && (byte_done_i || start_gen_ff);
	end

	// read data stand only in the cycle after the read strobe
	always_comb begin
		nxt_rdata_ff = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				isf_pkg::ADDR_STATUS_ONE: begin
					nxt_rdata_ff[isf_pkg::S1_BYTE_DONE] = byte_done_i;
					nxt_rdata_ff[isf_pkg::S1_MS] = ms_ff;
					nxt_rdata_ff[isf_pkg::S1_START_GEN] = start_gen_ff;
				end
				isf_pkg::ADDR_STATUS_TWO: begin
					nxt_rdata_ff[isf_pkg::S2_NO_REPLY] = no_reply_ff;
					nxt_rdata_ff[isf_pkg::S2_STOP_SEEN] = stop_seen_ff;
					nxt_rdata_ff[isf_pkg::S2_ARB_LOST] = arb_lost_ff;
					nxt_rdata_ff[isf_pkg::S2_BUS_ERR] = bus_err_ff;
					nxt_rdata_ff[isf_pkg::S2_GEN_CALL] = gen_call_ff;
				end
				isf_pkg::ADDR_CTRL: begin
					nxt_rdata_ff = {4'h0, ctrl_ff};
				end
				default: begin
					nxt_rdata_ff = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_ff <= isf_pkg::CTRL_RST;
			ms_ff <= 1'b0;
			start_gen_ff <= 1'b0;
			start_arm_ff <= 1'b0;
			no_reply_ff <= 1'b0;
			stop_seen_ff <= 1'b0;
			arb_lost_ff <= 1'b0;
			bus_err_ff <= 1'b0;
			gen_call_ff <= 1'b0;
			bus_ff <= isf_pkg::BUS_IDLE;
			cnt_ff <= isf_pkg::CNT_RST;
			shift_ff <= isf_pkg::STATUS_TWO_RST;
			first_ff <= 1'b0;
			ack_ff <= 1'b0;
			hold_ff <= 1'b0;
			rdata_ff <= isf_pkg::STATUS_TWO_RST;
		end else begin
			ctrl_ff <= nxt_ctrl_ff;
			ms_ff <= nxt_ms_ff;
			start_gen_ff <= nxt_start_gen_ff;
			start_arm_ff <= nxt_start_arm_ff;
			no_reply_ff <= nxt_no_reply_ff;
			stop_seen_ff <= nxt_stop_seen_ff;
			arb_lost_ff <= nxt_arb_lost_ff;
			bus_err_ff <= nxt_bus_err_ff;
			gen_call_ff <= nxt_gen_call_ff;
			bus_ff <= nxt_bus_ff;
			cnt_ff <= nxt_cnt_ff;
			shift_ff <= nxt_shift_ff;
			first_ff <= nxt_first_ff;
			ack_ff <= nxt_ack_ff;
			hold_ff <= nxt_hold_ff;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign scl_o = 1'b0;
	assign scl_oe_n_o = ~hold_ff;
	assign irq_o = ctrl_ff[isf_pkg::CTRL_IRQ_EN]
		&& (start_gen_ff || no_reply_ff || stop_seen_ff || arb_lost_ff || bus_err_ff);

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_begin_write;
		begin_wr;
	endsequence

	sequence s_start_release;
		(rd_one && start_gen_ff && unit_on)
			##[1:4] (wr_buf && start_arm_ff && !start_gen_set && unit_on);
	endsequence

	property p_ms_set;
		s_begin_write |=> ms_ff;
	endproperty
	a_ms_set: assert property (p_ms_set) else $error("master flag not set");

	property p_ms_clr;
		(stop_det || arb_lost_set) && !begin_wr |=> !ms_ff;
	endproperty
	a_ms_clr: assert property (p_ms_clr) else $error("master flag not cleared");

	property p_off_clr;
		!unit_on |=> !(ms_ff || start_gen_ff || no_reply_ff || stop_seen_ff || arb_lost_ff
			|| bus_err_ff || gen_call_ff);
	endproperty
	a_off_clr: assert property (p_off_clr) else $error("flags kept while off");

	property p_start_set;
		start_gen_set && unit_on |=> start_gen_ff;
	endproperty
	a_start_set: assert property (p_start_set) else $error("start flag not set");

	property p_start_clr;
		s_start_release |=> !start_gen_ff;
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("start flag not released");

	property p_start_keep;
		start_gen_ff && unit_on && !(wr_buf && start_arm_ff) |=> start_gen_ff;
	endproperty
	a_start_keep: assert property (p_start_keep) else $error("start flag lost");

	property p_rsv_zero;
		rd_two |=> reg_rdata_o[7:5] == 3'h0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

	property p_no_reply_set;
		ack_slot && sda_lvl && tx_active_i && unit_on
			|=> no_reply_ff ##1 (no_reply_ff || !unit_on || $past(rd_two));
	endproperty
	a_no_reply_set: assert property (p_no_reply_set) else $error("no reply flag missing");

	property p_rd_clr;
		rd_two && !(no_reply_set || stop_seen_set || arb_lost_set || bus_err_set)
			|=> !(no_reply_ff || stop_seen_ff || arb_lost_ff || bus_err_ff);
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("read did not clear");

	property p_hold_cause;
		!scl_oe_n_o |-> $past(unit_on && (byte_done_i || start_gen_ff));
	endproperty
	a_hold_cause: assert property (p_hold_cause) else $error("clock held wrongly");

	property p_done_hold;
		unit_on && byte_done_i |=> !scl_oe_n_o;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("clock not held");

	property p_stop_seen;
		stop_det && !ms_ff && ctrl_ff[isf_pkg::CTRL_ACK] && ack_ff && unit_on |=> stop_seen_ff;
	endproperty
	a_stop_seen: assert property (p_stop_seen) else $error("stop flag missing");

	property p_arb_lost;
		arb_lost_set && unit_on && !begin_wr |=> arb_lost_ff && !ms_ff;
	endproperty
	a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss mishandled");

	property p_no_arb_ack;
		ack_slot |-> !arb_lost_set;
	endproperty
	a_no_arb_ack: assert property (p_no_arb_ack) else $error("arbitration in ack");

	property p_bus_err;
		bus_err_set && unit_on |=> bus_err_ff;
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("bus error flag missing");

	property p_gen_call;
		gen_call_set && unit_on |=> gen_call_ff;
	endproperty
	a_gen_call: assert property (p_gen_call) else $error("general call flag missing");

	property p_gen_call_clr;
		stop_det && !gen_call_set |=> !gen_call_ff;
	endproperty
	a_gen_call_clr: assert property (p_gen_call_clr) else $error("general call kept");

	property p_irq;
		$rose(no_reply_ff) && ctrl_ff[isf_pkg::CTRL_IRQ_EN] |-> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

/* sim/isf_bus_model.sv */
// far-side i2c bus model: other masters and slaves driving both lines
`timescale 1ns/1ps
module isf_bus_model (
	input wire logic scl_w_i,
	output logic scl_o,
	output logic sda_o,
	output logic stall_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		stall_o = 1'b0;
	end
	// releases the clock and waits out stretching, bounded
	task automatic hi();
		int i;
		scl_o = 1'b1;
		for (i = 0; i < 2000 && scl_w_i !== 1'b1; i++)
			#10;
		if (scl_w_i !== 1'b1)
			stall_o = 1'b1;
	endtask
	task automatic bit_out(input logic b);
		sda_o = b;
		#20;
		hi();
		#40;
		scl_o = 1'b0;
		#10;
		sda_o = 1'b1;
		#10;
	endtask
	task automatic start();
		sda_o = 1'b1;
		#20;
		hi();
		#20;
		sda_o = 1'b0;
		#40;
		scl_o = 1'b0;
		#20;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		#20;
		hi();
		#20;
		sda_o = 1'b1;
		#40;
	endtask
	task automatic byte_out(input logic [7:0] d, input logic nak);
		int i;
		for (i = 7; i >= 0; i--)
			bit_out(d[i]);
		bit_out(nak);
	endtask
endmodule

/* sim/i2c_status_flag_logic_tb_top.sv */
// self-checking bench for the i2c status flag block
`timescale 1ns/1ps
module i2c_status_flag_logic_tb_top;
	localparam logic [3:0] A1 = isf_pkg::ADDR_STATUS_ONE;
	localparam logic [3:0] A2 = isf_pkg::ADDR_STATUS_TWO;
	localparam logic [3:0] AC = isf_pkg::ADDR_CTRL;
	localparam logic [3:0] AB = isf_pkg::ADDR_BYTE_BUF;
	logic clk, rst, wr_s, rd_s, scl_q, oe_n, bdone, txa, txb, irq;
	logic bm_scl, bm_sda, stall, scl_w;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	int n_fail, checks;
	// open-drain clock wire: low if either party pulls
	assign scl_w = bm_scl & (oe_n | scl_q);
	isf_core dut (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.scl_i(scl_w), .scl_o(scl_q), .scl_oe_n_o(oe_n), .sda_i(bm_sda),
		.byte_done_i(bdone), .tx_active_i(txa), .tx_bit_i(txb), .irq_o(irq));
	isf_bus_model bm (.scl_w_i(scl_w), .scl_o(bm_scl), .sda_o(bm_sda), .stall_o(stall));
	always #5 clk = ~clk;
	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("reg_rdata_o", rdata, exp);
	endtask
	task automatic pins(input logic ei, input logic eo);
		@(posedge clk);
		#1;
		chk("irq_o", {7'h00, irq}, {7'h00, ei});
		chk("scl_oe_n_o", {7'h00, oe_n}, {7'h00, eo});
		chk("scl_o", {7'h00, scl_q}, 8'h00);
	endtask
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask
	task automatic s_reset();
		pins(1'b0, 1'b1);
		rdc(A1, 8'h00);
		rdc(A2, isf_pkg::STATUS_TWO_RST);
		wr(A2, 8'hff);
		rdc(A2, 8'h00);
		rdc(4'h7, 8'h00);
	endtask
	task automatic s_master();
		wr(AC, 8'h03);
		wr(AC, 8'h13);
		rdc(A1, 8'h02);
		bm.start();
		settle();
		pins(1'b1, 1'b0);
		wr(AB, 8'ha0);
		pins(1'b1, 1'b0);
		rdc(A1, 8'h03);
		wr(AB, 8'ha0);
		rdc(A1, 8'h02);
		pins(1'b0, 1'b1);
	endtask
	task automatic s_noreply();
		@(posedge clk);
		txa <= 1'b1;
		txb <= 1'b1;
		bm.byte_out(8'hff, 1'b1);
		settle();
		pins(1'b1, 1'b1);
		rdc(A2, 8'h10);
		rdc(A2, 8'h00);
	endtask
	task automatic s_arb();
		bm.byte_out(8'hff, 1'b0);
		settle();
		rdc(A2, 8'h00);
		bm.bit_out(1'b0);
		settle();
		pins(1'b1, 1'b1);
		rdc(A2, 8'h04);
		rdc(A1, 8'h00);
		@(posedge clk);
		txa <= 1'b0;
		txb <= 1'b0;
	endtask
	task automatic s_bus_err();
		wr(AC, 8'h01);
		bm.bit_out(1'b1);
		bm.bit_out(1'b1);
		bm.start();
		bm.stop();
		settle();
		pins(1'b0, 1'b1);
		rdc(A2, 8'h02);
	endtask
	task automatic s_gen_call();
		wr(AC, 8'h0f);
		rdc(AC, 8'h0f);
		bm.start();
		bm.byte_out(isf_pkg::GEN_CALL_ADDR, 1'b0);
		settle();
		pins(1'b0, 1'b1);
		rdc(A2, 8'h01);
		@(posedge clk);
		#1;
		chk("reg_rdata_o", rdata, 8'h00);
		rdc(A2, 8'h01);
		bm.stop();
		settle();
		pins(1'b1, 1'b1);
		rdc(A2, 8'h08);
	endtask
	task automatic s_off();
		wr(AC, 8'h01);
		@(posedge clk);
		bdone <= 1'b1;
		settle();
		pins(1'b0, 1'b0);
		rdc(A1, 8'h08);
		bdone <= 1'b0;
		wr(AC, 8'h11);
		bm.start();
		settle();
		rdc(A1, 8'h03);
		wr(AC, 8'h00);
		rdc(A1, 8'h00);
		pins(1'b0, 1'b1);
	endtask
	initial begin
		#900000;
		n_fail++;
		summarize();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		bdone = 1'b0;
		txa = 1'b0;
		txb = 1'b0;
		n_fail = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_master();
		s_noreply();
		s_arb();
		s_bus_err();
		s_gen_call();
		s_off();
		chk("stall_o", {7'h00, stall}, 8'h00);
		summarize();
	end
endmodule
